// ==== core/ibdpe_host.sv ====
// two-wire bus master with an AXI4-Lite command port
//
// Added by the designer: the AXI4-Lite slave port and the address map.
module ibdpe_host
  import ibdpe_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // axi4-lite write
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // bus lines
  input wire logic sclIn,
  output logic sclO,
  output logic sclOe_b,
  input wire logic sdaIn,
  output logic sdaO,
  output logic sdaOe_b
);
  function automatic logic hit(input logic [7:0] c, input logic [7:0] t);
    return c == t;
  endfunction : hit

  function automatic logic [7:0] satInc(input logic [7:0] c);
    return (c == CNT_MAX) ? c : c + 8'h01;
  endfunction : satInc

  logic sclS;
  logic sdaS;
  ibdpe_state_e stateQ, stateD;
  logic [7:0] cntQ, cntD;
  logic [3:0] bitQ, bitD;
  logic [7:0] shQ, shD;
  logic sclOeBQ, sclOeBD;
  logic sdaOeBQ, sdaOeBD;
  logic highSeenQ, highSeenD;
  logic endByte;
  logic arbHit;
  logic fin;
  logic readQ, stopQ, nackBitQ;
  logic [7:0] txQ, rxQ;
  logic doneQ, nackQ, arbQ, busBusyQ, sdaPrevQ;
  logic awReadyQ, wReadyQ, bValidQ, arReadyQ, rValidQ;
  logic [1:0] bRespQ, rRespQ;
  logic [31:0] rDataQ;
  logic pinLowQ;

  // line sampling
  ibdpe_sync uSclSync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pinIn(sclIn),
    .level(sclS)
  );
  ibdpe_sync uSdaSync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pinIn(sdaIn),
    .level(sdaS)
  );

  // bus state from sampled lines
  wire startSeen = sclS && sdaPrevQ && !sdaS;
  wire stopSeen = sclS && !sdaPrevQ && sdaS;
  wire busFree = sclS && sdaS && !busBusyQ;

  // axi write decode
  wire wrTake = s_axi_awvalid && s_axi_wvalid && !awReadyQ && !bValidQ;
  wire wrEn = awReadyQ;
  wire lane0 = s_axi_wstrb[0];
  wire wrMapped = (s_axi_awaddr == ADDR_CMD) || (s_axi_awaddr == ADDR_TX)
                  || (s_axi_awaddr == ADDR_STAT);
  wire wrCmd = wrEn && lane0 && (s_axi_awaddr == ADDR_CMD);
  wire wrTx = wrEn && lane0 && (s_axi_awaddr == ADDR_TX);
  wire wrStat = wrEn && lane0 && (s_axi_awaddr == ADDR_STAT);
  wire clrDone = wrStat && s_axi_wdata[STAT_DONE];
  wire clrArb = wrStat && s_axi_wdata[STAT_ARB];

  // command decode
  wire cStart = s_axi_wdata[CMD_START];
  wire cXfer = s_axi_wdata[CMD_XFER];
  wire cRead = s_axi_wdata[CMD_READ];
  wire cNack = s_axi_wdata[CMD_NACK];
  wire cStop = s_axi_wdata[CMD_STOP];
  wire inIdle = stateQ == ST_IDLE;
  wire inHold = stateQ == ST_HOLD;
  wire badAddr = cStart && (txQ[7:1] == HOST_OWN_ADDR);
  wire cmdOk = wrCmd && (inIdle || inHold) && !badAddr;
  wire goStart = cmdOk && inIdle && cStart && busFree;
  wire startRefused = cmdOk && inIdle && cStart && !busFree;
  wire goRstart = cmdOk && inHold && cStart;
  wire goByte = cmdOk && inHold && !cStart && cXfer;
  wire goStopOnly = cmdOk && inHold && !cStart && !cXfer && cStop;
  wire latchCmd = goStart || goRstart || goByte || goStopOnly;
  wire engBusy = !inIdle && !inHold;

  // bit to put on sda: 1 means released
  wire isAck = bitQ == ACK_BIT;
  wire outBit = isAck ? (readQ ? nackBitQ : 1'b1) : (readQ ? 1'b1 : shQ[7]);
  wire wantHigh = !readQ && !isAck && sdaOeBQ;

  // axi read decode
  wire [31:0] statWord = {26'h0, !inIdle, busBusyQ, arbQ, nackQ, doneQ, engBusy};
  wire rdMapped = (s_axi_araddr == ADDR_CMD) || (s_axi_araddr == ADDR_TX)
                  || (s_axi_araddr == ADDR_STAT) || (s_axi_araddr == ADDR_RX);
  wire [31:0] rdMux = (s_axi_araddr == ADDR_TX) ? {24'h0, txQ} :
                      (s_axi_araddr == ADDR_STAT) ? statWord :
                      (s_axi_araddr == ADDR_RX) ? {24'h0, rxQ} : 32'h0;
  wire rdTake = s_axi_arvalid && !arReadyQ && !rValidQ;

  // bit engine
  always_comb begin
    stateD = stateQ;
    cntD = satInc(cntQ);
    bitD = bitQ;
    shD = shQ;
    sclOeBD = sclOeBQ;
    sdaOeBD = sdaOeBQ;
    highSeenD = highSeenQ;
    endByte = 1'b0;
    arbHit = 1'b0;
    fin = 1'b0;
    case (stateQ)
      ST_IDLE: begin
        cntD = 8'h00;
        sclOeBD = 1'b1;
        sdaOeBD = 1'b1;
        if (goStart) begin
          stateD = ST_START;
          sdaOeBD = 1'b0;
          shD = txQ;
          bitD = 4'h0;
        end
      end
      ST_HOLD: begin
        sclOeBD = 1'b0;
        if (hit(cntQ, QTR_CYC)) sdaOeBD = 1'b1;
        if (goRstart) begin
          stateD = ST_RSTART;
          cntD = 8'h00;
          shD = txQ;
          bitD = 4'h0;
        end else if (goByte) begin
          stateD = ST_LOW;
          cntD = 8'h00;
          shD = cRead ? 8'hFF : txQ;
          bitD = 4'h0;
        end else if (goStopOnly) begin
          stateD = ST_STOP;
          cntD = 8'h00;
        end
      end
      ST_START: begin
        if (hit(cntQ, HALF_CYC)) begin
          stateD = ST_LOW;
          sclOeBD = 1'b0;
          cntD = 8'h00;
        end
      end
      ST_LOW: begin
        if (hit(cntQ, QTR_CYC)) sdaOeBD = outBit;
        if (hit(cntQ, HALF_CYC)) begin
          stateD = ST_HIGH;
          sclOeBD = 1'b1;
          cntD = 8'h00;
          highSeenD = 1'b0;
        end
      end
      ST_HIGH: begin
        if (!highSeenQ) begin
          cntD = 8'h00;
          highSeenD = sclS;
        end else if (!sclS || hit(cntQ, HALF_CYC)) begin
          cntD = 8'h00;
          sclOeBD = 1'b0;
          if (wantHigh && !sdaS) begin
            arbHit = 1'b1;
            stateD = ST_IDLE;
            sclOeBD = 1'b1;
            sdaOeBD = 1'b1;
          end else if (isAck) begin
            endByte = 1'b1;
            stateD = stopQ ? ST_STOP : ST_HOLD;
          end else begin
            shD = {shQ[6:0], sdaS};
            bitD = bitQ + 4'h1;
            stateD = ST_LOW;
          end
        end
      end
      ST_RSTART: begin
        if (hit(cntQ, QTR_CYC)) sdaOeBD = 1'b1;
        if (hit(cntQ, HALF_CYC)) begin
          stateD = ST_RSHIGH;
          sclOeBD = 1'b1;
          cntD = 8'h00;
          highSeenD = 1'b0;
        end
      end
      ST_RSHIGH: begin
        if (!highSeenQ) begin
          cntD = 8'h00;
          highSeenD = sclS;
        end else if (hit(cntQ, HALF_CYC)) begin
          stateD = ST_START;
          sdaOeBD = 1'b0;
          cntD = 8'h00;
        end
      end
      ST_STOP: begin
        if (hit(cntQ, QTR_CYC)) sdaOeBD = 1'b0;
        if (hit(cntQ, HALF_CYC)) begin
          stateD = ST_STOPH;
          sclOeBD = 1'b1;
          cntD = 8'h00;
          highSeenD = 1'b0;
        end
      end
      ST_STOPH: begin
        if (!highSeenQ) begin
          cntD = 8'h00;
          highSeenD = sclS;
        end else if (hit(cntQ, HALF_CYC)) begin
          stateD = ST_STOPF;
          sdaOeBD = 1'b1;
          cntD = 8'h00;
        end
      end
      ST_STOPF: begin
        if (hit(cntQ, HALF_CYC)) begin
          stateD = ST_IDLE;
          fin = 1'b1;
        end
      end
      default: begin
        stateD = ST_IDLE;
        sclOeBD = 1'b1;
        sdaOeBD = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stateQ <= ST_IDLE;
      cntQ <= 8'h00;
      bitQ <= 4'h0;
      shQ <= 8'h00;
      sclOeBQ <= 1'b1;
      sdaOeBQ <= 1'b1;
      highSeenQ <= 1'b0;
    end else begin
      stateQ <= stateD;
      cntQ <= cntD;
      bitQ <= bitD;
      shQ <= shD;
      sclOeBQ <= sclOeBD;
      sdaOeBQ <= sdaOeBD;
      highSeenQ <= highSeenD;
    end
  end

  // command latch, data and flags; hardware set wins over clear
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      readQ <= 1'b0;
      stopQ <= 1'b0;
      nackBitQ <= 1'b0;
      txQ <= TX_RESET;
      rxQ <= RX_RESET;
      doneQ <= 1'b0;
      nackQ <= 1'b0;
      arbQ <= 1'b0;
      busBusyQ <= 1'b0;
      sdaPrevQ <= 1'b1;
      pinLowQ <= 1'b0;
    end else begin
      if (latchCmd) begin
        readQ <= cRead && !cStart;
        stopQ <= cStop;
        nackBitQ <= cNack;
      end
      if (wrTx) txQ <= s_axi_wdata[7:0];
      if (endByte && readQ) rxQ <= shQ;
      if (endByte) nackQ <= sdaS;
      doneQ <= (endByte && !stopQ) || fin || (doneQ && !clrDone);
      arbQ <= arbHit || startRefused || (arbQ && !clrArb);
      busBusyQ <= startSeen || (busBusyQ && !stopSeen);
      sdaPrevQ <= sdaS;
    end
  end

  // axi handshakes
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      awReadyQ <= 1'b0;
      wReadyQ <= 1'b0;
      bValidQ <= 1'b0;
      bRespQ <= RESP_OKAY;
      arReadyQ <= 1'b0;
      rValidQ <= 1'b0;
      rRespQ <= RESP_OKAY;
      rDataQ <= 32'h0;
    end else begin
      awReadyQ <= wrTake;
      wReadyQ <= wrTake;
      if (wrEn) begin
        bValidQ <= 1'b1;
        bRespQ <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bValidQ <= 1'b0;
      end
      arReadyQ <= rdTake;
      if (arReadyQ) begin
        rValidQ <= 1'b1;
        rDataQ <= rdMux;
        rRespQ <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rValidQ <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awReadyQ;
  assign s_axi_wready = wReadyQ;
  assign s_axi_bvalid = bValidQ;
  assign s_axi_bresp = bRespQ;
  assign s_axi_arready = arReadyQ;
  assign s_axi_rvalid = rValidQ;
  assign s_axi_rdata = rDataQ;
  assign s_axi_rresp = rRespQ;
  assign sclO = pinLowQ;
  assign sdaO = pinLowQ;
  assign sclOe_b = sclOeBQ;
  assign sdaOe_b = sdaOeBQ;

  // checks
  sequence s_stop_rise;
    stateQ == ST_STOPH ##1 stateQ == ST_STOPF;
  endsequence

  sequence s_rs_enter;
    stateQ == ST_HOLD && goRstart ##1 stateQ == ST_RSTART;
  endsequence

  a_start_bus_free: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (stateQ == ST_START && $past(stateQ) == ST_IDLE)
    |-> ($past(sclS) && $past(sdaS) && !$past(busBusyQ) && !sdaOeBQ && sclOeBQ))
    else $error("start issued on a busy bus");

  a_sda_low_only: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ($past(stateQ) == ST_LOW && $changed(sdaOeBQ)) |-> !$past(sclOeBQ))
    else $error("sda moved while scl released");

  a_msb_first_out: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (stateQ == ST_LOW && hit(cntQ, QTR_CYC) && bitQ == 4'h0 && !readQ)
    |=> (sdaOeBQ == $past(shQ[7])))
    else $error("first bit is not the top bit");

  a_stretch_stall: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (stateQ == ST_HIGH && !highSeenQ && !sclS) |=> (stateQ == ST_HIGH && cntQ == 8'h00))
    else $error("clock ran while scl held low");

  a_ack_sampled: assert property (@(posedge ref_clk) disable iff (!rst_b)
    endByte |=> (nackQ == $past(sdaS) && $past(bitQ) == ACK_BIT))
    else $error("acknowledge not taken on ninth clock");

  a_nack_driven: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (stateQ == ST_LOW && isAck && readQ && hit(cntQ, QTR_CYC))
    |=> (sdaOeBQ == $past(nackBitQ)))
    else $error("receiver acknowledge level wrong");

  a_stop_shape: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_stop_rise |-> (sdaOeBQ && $past(sclS) && !$past(sdaOeBQ)))
    else $error("stop edge not made with scl high");

  a_rstart_keep: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_rs_enter |-> (!sclOeBQ && !inIdle))
    else $error("repeated start released the bus");
endmodule : ibdpe_host

// ==== core/ibdpe_pkg.sv ====
// constants, register map and states of the two-wire host controller
package ibdpe_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCL_HALF_NS = 5000;
  localparam int HALF_CYC_I = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] HALF_CYC = 8'(HALF_CYC_I);
  localparam logic [7:0] QTR_CYC = 8'(HALF_CYC_I / 2);
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [3:0] ACK_BIT = 4'h8;
  // register byte addresses
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_TX = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [3:0] ADDR_RX = 4'hC;
  // command fields
  localparam int CMD_START = 0;
  localparam int CMD_XFER = 1;
  localparam int CMD_READ = 2;
  localparam int CMD_NACK = 3;
  localparam int CMD_STOP = 4;
  // status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_NACK = 2;
  localparam int STAT_ARB = 3;
  localparam int STAT_BUS = 4;
  localparam int STAT_OWN = 5;
  // reset values
  localparam logic [7:0] TX_RESET = 8'h00;
  localparam logic [7:0] RX_RESET = 8'h00;
  // own address the host never calls; value arbitrary
  localparam logic [6:0] HOST_OWN_ADDR = 7'h7F;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_LOW, ST_HIGH, ST_HOLD,
    ST_RSTART, ST_RSHIGH, ST_STOP, ST_STOPH, ST_STOPF
  } ibdpe_state_e;
endpackage : ibdpe_pkg

// ==== core/ibdpe_sync.sv ====
// three-stage pin sampler with agreement filter
module ibdpe_sync (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // raw pin
  input wire logic pinIn,
  // filtered level
  output logic level
);
  logic s1Q;
  logic s2Q;
  logic s3Q;
  logic levelQ;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s1Q <= 1'b1;
      s2Q <= 1'b1;
      s3Q <= 1'b1;
      levelQ <= 1'b1;
    end else begin
      s1Q <= pinIn;
      s2Q <= s1Q;
      s3Q <= s2Q;
      if (s2Q == s3Q) levelQ <= s3Q;
    end
  end

  assign level = levelQ;
endmodule : ibdpe_sync

// ==== dv/ibdpe_target.sv ====
// behavioural two-wire target holding one data byte
module ibdpe_target #(
  parameter logic [6:0] OWN_ADDR = 7'h2A,
  parameter logic [7:0] DATA_RESET = 8'h00
) (
  // bus lines
  input wire logic scl,
  input wire logic sda,
  output logic sclLow,
  output logic sdaLow,
  // misbehaviour on demand
  input wire logic decline,
  input wire logic stretch
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] busDataByte = DATA_RESET;
  logic [7:0] shiftIn = 8'h00;
  logic [3:0] risings = 4'h0;
  logic active = 1'b0;
  logic selected = 1'b0;
  logic readMode = 1'b0;
  logic addrPhase = 1'b0;
  logic masterNack = 1'b0;
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      active = 1'b1;
      addrPhase = 1'b1;
      selected = 1'b0;
      risings = 4'h0;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      active = 1'b0;
      selected = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (active) begin
      if (risings < 4'h8) shiftIn = {shiftIn[6:0], sda};
      else masterNack = sda;
      risings = risings + 4'h1;
    end
  end
  // sda only moves a little after scl has fallen
  always @(negedge scl) begin
    if (active && risings == 4'h8) begin
      if (addrPhase) begin
        selected = shiftIn[7:1] == OWN_ADDR;
        readMode = shiftIn[0];
      end else if (selected && !readMode && !decline) begin
        busDataByte = shiftIn;
      end
      sdaLow <= #200 selected && (addrPhase || !(readMode || decline));
    end else if (active && risings == 4'h9) begin
      if (!addrPhase && readMode && masterNack) selected = 1'b0;
      addrPhase = 1'b0;
      risings = 4'h0;
      sdaLow <= #200 selected && readMode && !busDataByte[7];
      if (stretch) begin
        sclLow = 1'b1;
        #8000 sclLow = 1'b0;
      end
    end else if (active && selected && readMode && !addrPhase) begin
      sdaLow <= #200 !busDataByte[3'(4'h7 - risings)];
    end
  end
endmodule : ibdpe_target

// ==== dv/testbench.sv ====
// self-checking bench for the two-wire host controller
module testbench
  import ibdpe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] TGT = 7'h2A;
  localparam logic [31:0] cStart = 32'h1 << CMD_START;
  localparam logic [31:0] cXfer = 32'h1 << CMD_XFER;
  localparam logic [31:0] cRead = 32'h1 << CMD_READ;
  localparam logic [31:0] cNack = 32'h1 << CMD_NACK;
  localparam logic [31:0] cStop = 32'h1 << CMD_STOP;
  logic ref_clk;
  logic rst_b = 1'b0;
  logic [3:0] awAddr = 4'h0;
  logic [3:0] arAddr = 4'h0;
  logic [3:0] wStrb = 4'hF;
  logic [31:0] wData = 32'h0;
  logic awValid = 1'b0;
  logic wValid = 1'b0;
  logic bReady = 1'b0;
  logic arValid = 1'b0;
  logic rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid, sclO, sclOe_b, sdaO, sdaOe_b;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  logic tgtSclLow, tgtSdaLow;
  logic decline = 1'b0;
  logic stretch = 1'b0;
  logic rivalSda = 1'b0;
  int failures = 0;
  int checked = 0;
  // open-drain lines with pull-ups
  wire sclLine = (sclOe_b | sclO) & !tgtSclLow;
  wire sdaLine = (sdaOe_b | sdaO) & !tgtSdaLow & !rivalSda;

  ibdpe_host i_ibdpe_host (
    .ref_clk(ref_clk), .rst_b(rst_b),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .sclIn(sclLine), .sclO(sclO), .sclOe_b(sclOe_b),
    .sdaIn(sdaLine), .sdaO(sdaO), .sdaOe_b(sdaOe_b)
  );
  ibdpe_target #(.OWN_ADDR(TGT), .DATA_RESET(8'h00)) i_ibdpe_target (
    .scl(sclLine), .sda(sdaLine), .sclLow(tgtSclLow), .sdaLow(tgtSdaLow),
    .decline(decline), .stretch(stretch)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic results;
    if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, want);
    end
  endtask : check

  task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, input logic [1:0] resp);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge ref_clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge ref_clk);
      if (awReady === 1'b1) begin
        awDone = 1'b1;
        awValid <= 1'b0;
      end
      if (wReady === 1'b1) begin
        wDone = 1'b1;
        wValid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (bValid !== 1'b1);
    bReady <= 1'b0;
    check(bResp, resp);
  endtask : axiWrite

  task automatic axiRead(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do @(posedge ref_clk); while (arReady !== 1'b1);
    arValid <= 1'b0;
    do @(posedge ref_clk); while (rValid !== 1'b1);
    rReady <= 1'b0;
    d = rData;
    r = rResp;
  endtask : axiRead

  task automatic rdChk(input logic [3:0] a, input logic [7:0] want, input logic [1:0] resp);
    logic [31:0] d;
    logic [1:0] r;
    axiRead(a, d, r);
    check({r, d[7:0]}, {resp, want});
  endtask : rdChk

  task automatic cmd(input logic [31:0] c);
    axiWrite(ADDR_CMD, c, RESP_OKAY);
  endtask : cmd

  // poll a status flag, then clear it by writing one
  task automatic waitFlag(input int b, output logic [31:0] st);
    logic [1:0] r;
    st = 32'h0;
    repeat (4000) if (st[b] !== 1'b1) axiRead(ADDR_STAT, st, r);
    check(st[b], 1);
    axiWrite(ADDR_STAT, 32'h1 << b, RESP_OKAY);
  endtask : waitFlag

  task automatic tRegs;
    logic [31:0] d;
    logic [1:0] r;
    rdChk(ADDR_TX, TX_RESET, RESP_OKAY);
    rdChk(ADDR_RX, RX_RESET, RESP_OKAY);
    rdChk(ADDR_STAT, 8'h00, RESP_OKAY);
    axiWrite(ADDR_TX, {24'h0, HOST_OWN_ADDR, 1'b0}, RESP_OKAY);
    cmd(cStart | cXfer);
    repeat (200) @(posedge ref_clk);
    rdChk(ADDR_STAT, 8'h00, RESP_OKAY);
    check({sclOe_b, sdaOe_b}, 2'b11);
    rdChk(ADDR_TX, {HOST_OWN_ADDR, 1'b0}, RESP_OKAY);
    rdChk(ADDR_CMD, 8'h00, RESP_OKAY);
    axiWrite(4'h2, 32'h0, RESP_SLVERR);
    axiRead(4'h2, d, r);
    check(r, RESP_SLVERR);
  endtask : tRegs

  task automatic tWrite;
    logic [31:0] st;
    stretch <= 1'b1;
    axiWrite(ADDR_TX, {24'h0, TGT, 1'b0}, RESP_OKAY);
    cmd(cStart | cXfer);
    waitFlag(STAT_DONE, st);
    check({st[STAT_NACK], i_ibdpe_target.selected}, 2'b01);
    axiWrite(ADDR_TX, 32'hC3, RESP_OKAY);
    cmd(cXfer);
    waitFlag(STAT_DONE, st);
    check(i_ibdpe_target.busDataByte, 8'hC3);
    decline <= 1'b1;
    axiWrite(ADDR_TX, 32'h3C, RESP_OKAY);
    cmd(cXfer | cStop);
    waitFlag(STAT_DONE, st);
    check(st[STAT_NACK], 1);
    check({st[STAT_BUS], st[STAT_OWN], i_ibdpe_target.active, sclLine, sdaLine}, 5'h03);
    decline <= 1'b0;
    stretch <= 1'b0;
  endtask : tWrite

  task automatic tRead;
    logic [31:0] st;
    axiWrite(ADDR_TX, {24'h0, TGT, 1'b0}, RESP_OKAY);
    cmd(cStart | cXfer);
    waitFlag(STAT_DONE, st);
    axiWrite(ADDR_TX, {24'h0, TGT, 1'b1}, RESP_OKAY);
    cmd(cStart | cXfer);
    waitFlag(STAT_DONE, st);
    check({st[STAT_NACK], i_ibdpe_target.readMode}, 2'b01);
    cmd(cXfer | cRead);
    waitFlag(STAT_DONE, st);
    rdChk(ADDR_RX, 8'hC3, RESP_OKAY);
    i_ibdpe_target.busDataByte = 8'h81;
    cmd(cXfer | cRead | cNack);
    waitFlag(STAT_DONE, st);
    rdChk(ADDR_RX, 8'h81, RESP_OKAY);
    check({i_ibdpe_target.selected, sdaLine}, 2'b01);
    cmd(cStop);
    waitFlag(STAT_DONE, st);
    check({i_ibdpe_target.selected, i_ibdpe_target.active}, 2'b00);
  endtask : tRead

  task automatic tArb;
    logic [31:0] st;
    logic [1:0] r;
    axiWrite(ADDR_TX, {24'h0, 7'h50, 1'b0}, RESP_OKAY);
    cmd(cStart | cXfer);
    axiRead(ADDR_STAT, st, r);
    check({st[STAT_OWN], st[STAT_BUSY]}, 2'b11);
    repeat (400) if (sclLine !== 1'b0) @(posedge ref_clk);
    rivalSda <= 1'b1;
    waitFlag(STAT_ARB, st);
    check({sclOe_b, sdaOe_b, st[STAT_BUS]}, 3'h7);
    cmd(cStart | cXfer);
    waitFlag(STAT_ARB, st);
    rivalSda <= 1'b0;
    repeat (10) @(posedge ref_clk);
    axiRead(ADDR_STAT, st, r);
    check(st[STAT_BUS], 0);
  endtask : tArb

  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge ref_clk);
    tRegs();
    tWrite();
    tRead();
    tArb();
    results();
  end

  initial begin
    #(90000 * 40);
    failures++;
    results();
  end
endmodule : testbench
